// ---- pkg/phy_cfg_regs.svh ----
// Register indices, write masks, reset values, status layout and field
// positions of the transmit level and equalizer configuration bank.
// Assumes a 32-bit AHB-Lite bus with one register per aligned word.
`ifndef PHY_CFG_REGS_SVH
`define PHY_CFG_REGS_SVH

// Printed register indices; the byte address is four times the index.
`define IDX_LVL_LOW 12'h30B
`define IDX_LVL_PLUS 12'h30C
`define IDX_ADAPT_CTL 12'h30F
`define IDX_GAIN_SEL 12'h311
`define IDX_STATUS 12'h310

// Writable bits of each register; all other bits read as zero.
`define MASK_LVL_LOW 16'h0FFF
`define MASK_LVL_PLUS 16'h003F
`define MASK_ADAPT_CTL 16'h07FF
`define MASK_GAIN_SEL 16'hE1FE

// Reset values.
`define RST_LVL_LOW 16'h0C00
`define RST_LVL_PLUS 16'h0020
`define RST_ADAPT_CTL 16'h0464
`define RST_GAIN_SEL 16'h01FC

// Field positions.
`define F_MINUS_MSB 11
`define F_MINUS_LSB 6
`define F_ZERO_MSB 5
`define F_ZERO_LSB 0
`define F_PLUS_MSB 5
`define F_PLUS_LSB 0
`define F_TIMER_MSB 10
`define F_TIMER_LSB 8
`define F_HOLD_ONE 7
`define F_HOLD_TWO 6
`define F_HOLD_THREE 5
`define F_CHECK_MSB 4
`define F_CHECK_LSB 2
`define F_FREQACC_BIT 1
`define F_DFE_RST_BIT 0
`define F_GAIN_MSB 15
`define F_GAIN_LSB 14
`define F_COEF_SET_BIT 13
`define F_COEF0_MSB 8
`define F_COEF0_LSB 1

// Status register layout.
`define F_ST_CODE_MSB 5
`define F_ST_CODE_LSB 0
`define F_ST_HOLD_BIT 6
`define F_ST_CNT_MSB 15
`define F_ST_CNT_LSB 8

`endif

// ---- pkg/phy_cfg_pkg.sv ----
// Types shared by the configuration bank and its bench.
// Assumes phy_cfg_regs.svh supplies the numeric constants.
package phy_cfg_pkg;

    // Transmitted three-level symbol from the encoder.
    typedef enum logic [1:0] {
        SYM_ZERO = 2'h0,
        SYM_PLUS = 2'h1,
        SYM_MINUS = 2'h2
    } tx_symbol_t;

    // Current adaptation stage reported by the sequencer.
    typedef enum logic [1:0] {
        STAGE_OTHER = 2'h0,
        STAGE_ONE = 2'h1,
        STAGE_TWO = 2'h2,
        STAGE_THREE = 2'h3
    } adapt_stage_t;

    // Complete state of the bank.
    typedef struct packed {
        logic [15:0] lvl_low;
        logic [15:0] lvl_plus;
        logic [15:0] adapt_ctl;
        logic [15:0] gain_sel;
        logic wr_pend;
        logic [11:0] wr_idx;
        logic [31:0] rdata;
        logic [5:0] line_code;
        logic ff_freeze;
        logic freqacc_reinit;
        logic dfe_coeff_reset;
        logic [7:0] sweep_cnt;
        logic coeff0_force;
    } state_t;

endpackage : phy_cfg_pkg

// ---- verilog/phy_tx_level_and_equalizer_config.sv ----
// Transmit level and equalizer configuration bank with an AHB-Lite slave.
// Assumes tx_symbol, adapt_stage, sweep_iter and short_cable come from
// logic on clk_sys, so none of them is synchronised here.
`include "phy_cfg_regs.svh"

module phy_tx_level_and_equalizer_config (
    input wire logic clk_sys,
    input wire logic resetn,
    // AHB-Lite slave.
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // Transmit side.
    input wire phy_cfg_pkg::tx_symbol_t tx_symbol,
    output logic [5:0] line_code,
    // Adaptation sequencer side.
    input wire phy_cfg_pkg::adapt_stage_t adapt_stage,
    input wire logic sweep_active,
    input wire logic sweep_iter,
    input wire logic short_cable,
    output logic [2:0] stage_one_timer_select,
    output logic ff_freeze,
    output logic [2:0] thr_check_en,
    output logic freqacc_reinit,
    output logic dfe_coeff_reset,
    output logic [1:0] gain_map_sel,
    output logic coeff_set_sel,
    output logic coeff0_force,
    output logic [7:0] coeff0_value
);

    phy_cfg_pkg::state_t s_q;
    phy_cfg_pkg::state_t s_d;

    // Word index of a byte address; upper address bits must be zero.
    function automatic logic [11:0] word_index(input logic [31:0] addr);
        logic [11:0] idx;
        idx = 12'hFFF;
        if (addr[31:14] == 18'h00000 && addr[1:0] == 2'h0) begin
            idx = addr[13:2];
        end
        return idx;
    endfunction : word_index

    // Merges a write into a register, keeping only the implemented bits.
    function automatic logic [15:0] masked_write(
        input logic [15:0] old_val,
        input logic [31:0] wdata,
        input logic [15:0] mask
    );
        return (old_val & ~mask) | (wdata[15:0] & mask);
    endfunction : masked_write

    // Chooses the driver code for a symbol. An illegal symbol code falls
    // back to the zero level so the driver never sees a stale value.
    function automatic logic [5:0] level_for(
        input phy_cfg_pkg::tx_symbol_t sym,
        input logic [15:0] low_reg,
        input logic [15:0] plus_reg
    );
        logic [5:0] code;
        code = low_reg[`F_ZERO_MSB:`F_ZERO_LSB];
        unique case (sym)
            phy_cfg_pkg::SYM_MINUS: begin
                code = low_reg[`F_MINUS_MSB:`F_MINUS_LSB];
            end
            phy_cfg_pkg::SYM_PLUS: begin
                code = plus_reg[`F_PLUS_MSB:`F_PLUS_LSB];
            end
            default: begin
                code = low_reg[`F_ZERO_MSB:`F_ZERO_LSB];
            end
        endcase
        return code;
    endfunction : level_for

    // Read-only status word showing the block's own state.
    function automatic logic [15:0] status_word(input phy_cfg_pkg::state_t st);
        logic [15:0] w;
        w = 16'h0000;
        w[`F_ST_CODE_MSB:`F_ST_CODE_LSB] = st.line_code;
        w[`F_ST_HOLD_BIT] = st.ff_freeze;
        w[`F_ST_CNT_MSB:`F_ST_CNT_LSB] = st.sweep_cnt;
        return w;
    endfunction : status_word

    logic addr_take;
    logic [11:0] addr_idx;
    logic [15:0] rd_word;
    logic hold_bit;

    // An address phase is taken only when the bus is ready and the
    // transfer is NONSEQ or SEQ; IDLE and BUSY are ignored.
    assign addr_take = hsel && hready && htrans[1];
    assign addr_idx = word_index(haddr);

    // Next-state logic for the whole bank.
    always_comb begin
        s_d = s_q;
        s_d.freqacc_reinit = 1'b0;
        s_d.dfe_coeff_reset = 1'b0;

        // Data phase of a write: the value lands at the end of this
        // cycle. Unmapped indices and the status word take no write.
        if (s_q.wr_pend) begin
            unique case (s_q.wr_idx)
                `IDX_LVL_LOW: begin
                    s_d.lvl_low = masked_write(s_q.lvl_low, hwdata, `MASK_LVL_LOW);
                end
                `IDX_LVL_PLUS: begin
                    s_d.lvl_plus = masked_write(s_q.lvl_plus, hwdata, `MASK_LVL_PLUS);
                end
                `IDX_ADAPT_CTL: begin
                    s_d.adapt_ctl = masked_write(s_q.adapt_ctl, hwdata, `MASK_ADAPT_CTL);
                end
                `IDX_GAIN_SEL: begin
                    s_d.gain_sel = masked_write(s_q.gain_sel, hwdata, `MASK_GAIN_SEL);
                end
                default: begin
                    s_d.gain_sel = s_q.gain_sel;
                end
            endcase
        end

        // Capture the next address phase; the write flag clears itself.
        s_d.wr_pend = addr_take && hwrite;
        s_d.wr_idx = addr_take ? addr_idx : s_q.wr_idx;

        // The read word is taken from the post-write values so that a read
        // right behind a write to the same register sees the new data.
        rd_word = 16'h0000;
        unique case (addr_idx)
            `IDX_LVL_LOW: begin
                rd_word = s_d.lvl_low;
            end
            `IDX_LVL_PLUS: begin
                rd_word = s_d.lvl_plus;
            end
            `IDX_ADAPT_CTL: begin
                rd_word = s_d.adapt_ctl;
            end
            `IDX_GAIN_SEL: begin
                rd_word = s_d.gain_sel;
            end
            `IDX_STATUS: begin
                rd_word = status_word(s_q);
            end
            default: begin
                rd_word = 16'h0000;
            end
        endcase
        if (addr_take && !hwrite) begin
            s_d.rdata = {16'h0000, rd_word};
        end

        // Driver code follows the symbol one cycle later.
        s_d.line_code = level_for(tx_symbol, s_q.lvl_low, s_q.lvl_plus);

        // Feed-forward freeze for the stage now running.
        hold_bit = 1'b0;
        unique case (adapt_stage)
            phy_cfg_pkg::STAGE_ONE: begin
                hold_bit = s_q.adapt_ctl[`F_HOLD_ONE];
            end
            phy_cfg_pkg::STAGE_TWO: begin
                hold_bit = s_q.adapt_ctl[`F_HOLD_TWO];
            end
            phy_cfg_pkg::STAGE_THREE: begin
                hold_bit = s_q.adapt_ctl[`F_HOLD_THREE];
            end
            phy_cfg_pkg::STAGE_OTHER: begin
                hold_bit = 1'b0;
            end
        endcase
        s_d.ff_freeze = hold_bit;

        // Each sweep iteration may clear the accumulator and the feedback
        // coefficients; both requests are single-cycle pulses.
        if (sweep_iter) begin
            s_d.freqacc_reinit = s_q.adapt_ctl[`F_FREQACC_BIT];
            s_d.dfe_coeff_reset = s_q.adapt_ctl[`F_DFE_RST_BIT];
            s_d.sweep_cnt = s_q.sweep_cnt + 8'h01;
        end

        // The forced coefficient applies only while the cable is short.
        s_d.coeff0_force = short_cable;
    end

    // Single register stage for all state.
    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            s_q.lvl_low <= `RST_LVL_LOW;
            s_q.lvl_plus <= `RST_LVL_PLUS;
            s_q.adapt_ctl <= `RST_ADAPT_CTL;
            s_q.gain_sel <= `RST_GAIN_SEL;
            s_q.wr_pend <= 1'b0;
            s_q.wr_idx <= 12'h000;
            s_q.rdata <= 32'h00000000;
            s_q.line_code <= 6'h00;
            s_q.ff_freeze <= 1'b0;
            s_q.freqacc_reinit <= 1'b0;
            s_q.dfe_coeff_reset <= 1'b0;
            s_q.sweep_cnt <= 8'h00;
            s_q.coeff0_force <= 1'b0;
        end else begin
            s_q <= s_d;
        end
    end

    // The slave never inserts wait states and never signals an error.
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = s_q.rdata;

    // Datapath-facing outputs, taken from flip-flops; thr_check_en is also gated directly by the sweep_active input.
    assign line_code = s_q.line_code;
    assign stage_one_timer_select = s_q.adapt_ctl[`F_TIMER_MSB:`F_TIMER_LSB];
    assign ff_freeze = s_q.ff_freeze;
    // Checks are offered only while a sweep is running.
    assign thr_check_en = sweep_active ? s_q.adapt_ctl[`F_CHECK_MSB:`F_CHECK_LSB]
        : 3'h0;
    assign freqacc_reinit = s_q.freqacc_reinit;
    assign dfe_coeff_reset = s_q.dfe_coeff_reset;
    // Code 3 is not a defined mapping, so it reads back as written but the
    // gain control falls back to the default combination.
    assign gain_map_sel = (s_q.gain_sel[`F_GAIN_MSB:`F_GAIN_LSB] == 2'h3) ? 2'h0
        : s_q.gain_sel[`F_GAIN_MSB:`F_GAIN_LSB];
    assign coeff_set_sel = s_q.gain_sel[`F_COEF_SET_BIT];
    assign coeff0_force = s_q.coeff0_force;
    assign coeff0_value = s_q.gain_sel[`F_COEF0_MSB:`F_COEF0_LSB];

endmodule : phy_tx_level_and_equalizer_config

// ---- bench/phy_cfg_checker_sva.sv ----
// Port-level assertions for the transmit level and equalizer configuration bank.
// Assumes one clock, clk_sys, and the synchronous active-low resetn.
module phy_cfg_checker (
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic hsel,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    input wire phy_cfg_pkg::adapt_stage_t adapt_stage,
    input wire logic sweep_active,
    input wire logic sweep_iter,
    input wire logic short_cable,
    input wire logic ff_freeze,
    input wire logic [2:0] thr_check_en,
    input wire logic freqacc_reinit,
    input wire logic dfe_coeff_reset,
    input wire logic [1:0] gain_map_sel,
    input wire logic coeff0_force
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking dc @(posedge clk_sys);
    endclocking
    default disable iff (!resetn);
    // A read address phase taken; read data may change only after one.
    wire logic rd_taken = hsel & hready & htrans[1] & ~hwrite;

    AST_FA_CAUSE:
    assert property (freqacc_reinit |-> $past(sweep_iter)) else $error("reinit without sweep step");
    AST_DFE_CAUSE:
    assert property (dfe_coeff_reset |-> $past(sweep_iter)) else $error("dfe reset without step");
    AST_FA_SINGLE:
    assert property (freqacc_reinit && !sweep_iter |=> !freqacc_reinit)
        else $error("reinit pulse too long");
    AST_THR_GATE:
    assert property (!sweep_active |-> thr_check_en == 3'h0) else $error("checks on outside sweep");
    AST_GAIN_RANGE:
    assert property (gain_map_sel != 2'h3) else $error("gain mapping out of range");
    AST_FORCE_LAG:
    assert property ($past(resetn) |-> coeff0_force == $past(short_cable))
        else $error("coefficient force does not follow cable");
    AST_FREEZE_IDLE:
    assert property ($past(resetn) && $past(adapt_stage) == phy_cfg_pkg::STAGE_OTHER |-> !ff_freeze)
        else $error("freeze outside stages");
    AST_RD_UPPER:
    assert property (hrdata[31:16] == 16'h0000) else $error("upper read bits set");
    AST_RD_HOLD:
    assert property ($past(resetn) && !$past(rd_taken) |-> $stable(hrdata))
        else $error("read data moved without read");

    // The main scenarios the bench is expected to reach.
    COV_SWEEP: cover property (sweep_iter ##1 freqacc_reinit);
    COV_READ: cover property (rd_taken);
    COV_FORCE: cover property (coeff0_force);
endmodule : phy_cfg_checker

bind phy_tx_level_and_equalizer_config phy_cfg_checker u_chk (
    .clk_sys(clk_sys), .resetn(resetn), .hsel(hsel), .htrans(htrans), .hwrite(hwrite),
    .hready(hready), .hrdata(hrdata), .adapt_stage(adapt_stage), .sweep_active(sweep_active),
    .sweep_iter(sweep_iter), .short_cable(short_cable), .ff_freeze(ff_freeze),
    .thr_check_en(thr_check_en), .freqacc_reinit(freqacc_reinit),
    .dfe_coeff_reset(dfe_coeff_reset), .gain_map_sel(gain_map_sel), .coeff0_force(coeff0_force)
);

// ---- bench/phy_tx_level_and_equalizer_config_tb.sv ----
// Self-checking bench for the transmit level and equalizer configuration bank.
// Assumes the constants header and the shared package are compiled before it.
`include "phy_cfg_regs.svh"

module phy_tx_level_and_equalizer_config_tb;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk_sys, resetn, hsel, hwrite, sweep_active, sweep_iter, short_cable;
    logic [31:0] haddr, hwdata, rd;
    logic [1:0] htrans;
    phy_cfg_pkg::tx_symbol_t tx_symbol;
    phy_cfg_pkg::adapt_stage_t adapt_stage;
    wire logic hreadyout, hresp, ff_freeze, freqacc_reinit, dfe_coeff_reset;
    wire logic coeff_set_sel, coeff0_force;
    wire logic [31:0] hrdata;
    wire logic [5:0] line_code;
    wire logic [2:0] stage_one_timer_select, thr_check_en;
    wire logic [1:0] gain_map_sel;
    wire logic [7:0] coeff0_value;
    int err_total, checks_done, cyc;
    logic [31:0] addrs [4] = '{32'h0C2C, 32'h0C30, 32'h0C3C, 32'h0C44};
    logic [15:0] rsts [4] = '{`RST_LVL_LOW, `RST_LVL_PLUS, `RST_ADAPT_CTL, `RST_GAIN_SEL};
    logic [15:0] masks [4] = '{`MASK_LVL_LOW, `MASK_LVL_PLUS, `MASK_ADAPT_CTL, `MASK_GAIN_SEL};

    phy_tx_level_and_equalizer_config u_dut (
        .clk_sys(clk_sys), .resetn(resetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .tx_symbol(tx_symbol),
        .line_code(line_code), .adapt_stage(adapt_stage), .sweep_active(sweep_active),
        .sweep_iter(sweep_iter), .short_cable(short_cable),
        .stage_one_timer_select(stage_one_timer_select), .ff_freeze(ff_freeze),
        .thr_check_en(thr_check_en), .freqacc_reinit(freqacc_reinit),
        .dfe_coeff_reset(dfe_coeff_reset), .gain_map_sel(gain_map_sel),
        .coeff_set_sel(coeff_set_sel), .coeff0_force(coeff0_force), .coeff0_value(coeff0_value)
    );

    task automatic give_verdict;
        $display("checks %0d mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : give_verdict

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            err_total++;
            $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    // One single transfer; the address phase is held until hready is seen high.
    task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= 2'h2;
        hwrite <= w;
        do @(posedge clk_sys); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hsel <= 1'b0;
        hwdata <= d;
        do @(posedge clk_sys); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask : xfer

    task automatic rdchk(input logic [31:0] a, input logic [31:0] exp);
        xfer(1'b0, a, 32'h0000_0000);
        chk(rd, exp);
        // The slave must answer at once and always with OKAY.
        chk({hreadyout, hresp}, 2'h2);
    endtask : rdchk

    // Let the next edge land, then sample away from it.
    task automatic nxt;
        @(posedge clk_sys);
        #1;
    endtask : nxt

    // Two sweep steps apart are never needed, so the pulse is checked then cleared.
    task automatic pulse(input logic [1:0] e);
        @(posedge clk_sys);
        sweep_iter <= 1'b1;
        @(posedge clk_sys);
        sweep_iter <= 1'b0;
        #1;
        chk(freqacc_reinit, e[1]);
        chk(dfe_coeff_reset, e[0]);
        nxt;
        chk({freqacc_reinit, dfe_coeff_reset}, 2'h0);
    endtask : pulse

    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end

    // A hang is cut short well beyond the under two hundred cycles the tests need.
    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 4000) begin
            err_total++;
            give_verdict();
        end
    end

    initial begin
        {resetn, hsel, hwrite, sweep_active, sweep_iter, short_cable} = '0;
        {haddr, hwdata, htrans} = '0;
        tx_symbol = phy_cfg_pkg::SYM_ZERO;
        adapt_stage = phy_cfg_pkg::STAGE_OTHER;
        repeat (20) @(posedge clk_sys);
        resetn <= 1'b1;
        // Reset values, then all ones to show which bits hold.
        foreach (addrs[i]) rdchk(addrs[i], {16'h0000, rsts[i]});
        foreach (addrs[i]) begin
            xfer(1'b1, addrs[i], 32'hFFFF_FFFF);
            rdchk(addrs[i], {16'h0000, masks[i]});
        end
        // An alias above the decoded range, an unmapped word and the status word must not land.
        xfer(1'b1, 32'h0000_4C30, 32'h0000_0000);
        xfer(1'b1, 32'h0000_0C48, 32'h0000_FFFF);
        xfer(1'b1, 32'h0000_0C40, 32'h0000_FFFF);
        rdchk(32'h0000_0C30, {16'h0000, `MASK_LVL_PLUS});
        rdchk(32'h0000_0C48, 32'h0000_0000);
        // Status shows the zero-level code 3F, no freeze and no sweep steps yet.
        rdchk(32'h0000_0C40, 32'h0000_003F);
        // Driver codes for each symbol; the illegal code falls back to zero level.
        xfer(1'b1, 32'h0C2C, 32'h0000_0A95);
        xfer(1'b1, 32'h0C30, 32'h0000_0033);
        for (int i = 0; i < 4; i++) begin
            @(posedge clk_sys);
            tx_symbol <= phy_cfg_pkg::tx_symbol_t'(2'((i + 2) % 4));
            nxt;
            chk(line_code, (i == 0) ? 6'h2A : (i == 3) ? 6'h33 : 6'h15);
        end
        // Timer 3, freeze in stages one and three, checks 6, both sweep actions.
        xfer(1'b1, 32'h0C3C, 32'h0000_03BB);
        nxt;
        chk(stage_one_timer_select, 3'h3);
        for (int s = 1; s < 5; s++) begin
            @(posedge clk_sys);
            adapt_stage <= phy_cfg_pkg::adapt_stage_t'(2'(s % 4));
            nxt;
            chk(ff_freeze, (s == 1 || s == 3) ? 1'b1 : 1'b0);
        end
        @(posedge clk_sys);
        sweep_active <= 1'b1;
        #1;
        chk(thr_check_en, 3'h6);
        pulse(2'h3);
        xfer(1'b1, 32'h0C3C, 32'h0000_0000);
        pulse(2'h0);
        // Two sweep steps counted; the plus-one code 33 is still driven.
        rdchk(32'h0000_0C40, 32'h0000_0233);
        // Gain mapping codes including the unused fourth, set select and forced value.
        for (int g = 0; g < 4; g++) begin
            xfer(1'b1, 32'h0C44, 32'((g << 14) | ((g & 1) << 13) | ((8'h5A ^ g) << 1)));
            nxt;
            chk(gain_map_sel, 32'((g == 3) ? 0 : g));
            chk(coeff_set_sel, 32'(g & 1));
            chk(coeff0_value, 32'(8'h5A ^ g));
        end
        for (int v = 1; v >= 0; v--) begin
            @(posedge clk_sys);
            short_cable <= 1'(v);
            nxt;
            chk(coeff0_force, 32'(v));
        end
        // A second reset in mid-run must bring every register back to its reset value.
        @(posedge clk_sys);
        resetn <= 1'b0;
        repeat (2) @(posedge clk_sys);
        resetn <= 1'b1;
        foreach (addrs[i]) rdchk(addrs[i], {16'h0000, rsts[i]});
        give_verdict();
    end
endmodule : phy_tx_level_and_equalizer_config_tb
